// file: inc/stop_wake_defs.svh
// constants of the stop-wake group source: offsets, fields, reset values, pin groups
`ifndef STOP_WAKE_DEFS_SVH
`define STOP_WAKE_DEFS_SVH

// register offsets
`define SW_ADDR_W       12
`define SW_P2SEL_OFS    12'hf0c
`define SW_GROUP_OFS    12'hf0d
`define SW_P3SEL_OFS    12'hf0e
`define SW_STATUS_OFS   12'hf10
`define SW_MASK_OFS     12'hf11

// group register fields
`define SW_LEVEL_BIT    6
`define SW_SRC_HI       4
`define SW_SRC_LO       2

// status and mask bits
`define SW_ST_GROUP     0
`define SW_ST_PIN       1
`define SW_ST_W         2

// reset values
`define SW_GROUP_RST    8'h00
`define SW_SEL_RST      8'h00
`define SW_P3SEL_RST    4'h0
`define SW_ST_RST       2'h0
`define SW_PIN_RST      14'h3fff
`define SW_RD_ZERO      8'h00

// pin vector layout: port 2 in [7:0], port 3 pins 3..0 in [11:8], port 0 pin 0 in [12], pin 7 in [13]
`define SW_NPINS        14
`define SW_MASK_NONE    14'h0000
`define SW_MASK_P2LO    14'h000f
`define SW_MASK_P2ALL   14'h00ff
`define SW_MASK_P3HI    14'h0e00
`define SW_MASK_P3P0    14'h3e00
`define SW_MASK_P3P2    14'h0e07

`endif

// file: inc/stop_wake_pkg.sv
// types of the stop-wake group source
package stop_wake_pkg;

   typedef enum logic [2:0] {
      SRC_NONE      = 3'b000,
      SRC_NAND_P2LO = 3'b001,
      SRC_NAND_P2   = 3'b010,
      SRC_NAND_P3   = 3'b011,
      SRC_NOR_P3    = 3'b100,
      SRC_NOR_P3P0  = 3'b101,
      SRC_NAND_P3P0 = 3'b110,
      SRC_NAND_P3P2 = 3'b111
   } wake_src_t;

endpackage

// file: src/wake_gate.sv
// one NAND/NOR gate over a masked group of wake pins
`timescale 1ns/1ns

module wake_gate #(
   parameter int N = 14
) (
   // pins and selection
   input  wire logic [N-1:0] pins,
   input  wire logic [N-1:0] inGroup,
   input  wire logic         useNor,
   // result
   output logic              gateOut,
   output logic              active
);

   // -----------------------------------------------------------
   // gate
   // -----------------------------------------------------------
   // left-out pins are forced to the value that cannot move the gate
   always_comb begin
      if (useNor) begin
         gateOut = ~|(pins & inGroup);
      end else begin
         gateOut = ~&(pins | ~inGroup);
      end
      active = |inGroup;
   end

endmodule // wake_gate

// file: src/stop_wake_source.sv
// group wake source: configuration registers, pin gates, wake request and interrupt
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`include "stop_wake_defs.svh"

// How it works
// - three-bit source field picks one of seven pin-gate modes
// - gate output equal to level bit raises a wake event
// - source code zero selects nothing, so no group event
// - pins driven as outputs or claimed by per-pin selects are ignored
// - level bit zero wakes on low gate output, one on high
// - any one enabled source causes stop recovery
// - code 001 NANDs port2 3..0; 111 NANDs port3 3..1 with port2 2..0
// - group register keeps its contents across a stop recovery
module stop_wake_source
   import stop_wake_pkg::*;
(
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   // register port
   input  wire logic [`SW_ADDR_W-1:0]  regAddr,
   input  wire logic [7:0]             regWdata,
   input  wire logic                   regWrite,
   input  wire logic                   regRead,
   output logic      [7:0]             regRdata,
   // pins
   input  wire logic [7:0]             port2Pin,
   input  wire logic [3:0]             port3Pin,
   input  wire logic                   port0Pin0,
   input  wire logic                   port0Pin7,
   // pin directions, high while the pin is an output
   input  wire logic [7:0]             port2Output,
   input  wire logic [3:0]             port3Output,
   input  wire logic                   port0Output0,
   input  wire logic                   port0Output7,
   // per-pin compare events
   input  wire logic                   perPinWake,
   // results
   output logic                        groupWake,
   output logic                        wakeRequest,
   output logic                        irq,
   output logic [7:0]                  port2PinSelect,
   output logic [3:0]                  port3PinSelect
);

   // -----------------------------------------------------------
   // declarations
   // -----------------------------------------------------------
   logic [7:0]            groupSelect;
   logic [`SW_ST_W-1:0]   status;
   logic [`SW_ST_W-1:0]   mask;
   logic [`SW_ST_W-1:0]   next_status;
   logic [`SW_ST_W-1:0]   statusSet;
   logic [`SW_NPINS-1:0]  pinRaw;
   logic [`SW_NPINS-1:0]  pinSync1;
   logic [`SW_NPINS-1:0]  pinSync2;
   logic [`SW_NPINS-1:0]  pinSync3;
   logic [`SW_NPINS-1:0]  pinAgree;
   logic [`SW_NPINS-1:0]  pinState;
   logic [`SW_NPINS-1:0]  pinIgnore;
   logic [`SW_NPINS-1:0]  modeMask;
   logic [`SW_NPINS-1:0]  inGroup;
   logic                  modeNor;
   logic                  level;
   wake_src_t             source;
   logic                  rawGate;
   logic                  rawActive;
   logic                  syncGate;
   logic                  syncActive;
   logic                  syncGroupWake;
   logic                  wrGroup;
   logic                  wrPort2;
   logic                  wrPort3;
   logic                  wrMask;
   logic                  rdStatus;
   logic                  rdMask;

   // -----------------------------------------------------------
   // register decode
   // -----------------------------------------------------------
   always_comb begin
      wrGroup  = regWrite && (regAddr == `SW_GROUP_OFS);
      wrPort2  = regWrite && (regAddr == `SW_P2SEL_OFS);
      wrPort3  = regWrite && (regAddr == `SW_P3SEL_OFS);
      wrMask   = regWrite && (regAddr == `SW_MASK_OFS);
      rdStatus = regRead && (regAddr == `SW_STATUS_OFS);
      rdMask   = regRead && (regAddr == `SW_MASK_OFS);
   end

   // -----------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------
   // only reset clears these; a stop recovery has no path in here
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         groupSelect <= `SW_GROUP_RST;
      end else if (wrGroup) begin
         // reserved bits are kept as written; nothing reads them back
         groupSelect <= regWdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         port2PinSelect <= `SW_SEL_RST;
      end else if (wrPort2) begin
         port2PinSelect <= regWdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         port3PinSelect <= `SW_P3SEL_RST;
      end else if (wrPort3) begin
         port3PinSelect <= regWdata[3:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask <= `SW_ST_RST;
      end else if (wrMask) begin
         mask <= regWdata[`SW_ST_W-1:0];
      end
   end

   // -----------------------------------------------------------
   // pin vector and exclusion
   // -----------------------------------------------------------
   // port 0 has no per-pin select, so only its direction can drop a pin
   always_comb begin
      pinRaw    = {port0Pin7, port0Pin0, port3Pin, port2Pin};
      pinIgnore = {port0Output7, port0Output0,
                   port3Output | port3PinSelect,
                   port2Output | port2PinSelect};
   end

   // -----------------------------------------------------------
   // pin synchronisers for the clocked status path
   // -----------------------------------------------------------
   // filtered pins only feed status; the wake request must not wait for a clock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pinSync1 <= `SW_PIN_RST;
         pinSync2 <= `SW_PIN_RST;
         pinSync3 <= `SW_PIN_RST;
      end else begin
         pinSync1 <= pinRaw;
         pinSync2 <= pinSync1;
         pinSync3 <= pinSync2;
      end
   end

   // a pin change is taken only once the last two stages agree
   always_comb begin
      pinAgree = ~(pinSync2 ^ pinSync3);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pinState <= `SW_PIN_RST;
      end else begin
         pinState <= (pinSync3 & pinAgree) | (pinState & ~pinAgree);
      end
   end

   // -----------------------------------------------------------
   // source decode
   // -----------------------------------------------------------
   always_comb begin
      source = wake_src_t'(groupSelect[`SW_SRC_HI:`SW_SRC_LO]);
      level  = groupSelect[`SW_LEVEL_BIT];
   end

   // pin groups of codes 010 to 110 are not yet confirmed; a mask edit here fixes them
   always_comb begin
      modeMask = `SW_MASK_NONE;
      modeNor  = 1'b0;
      case (source)
         SRC_NONE: begin
            modeMask = `SW_MASK_NONE;
         end
         SRC_NAND_P2LO: begin
            modeMask = `SW_MASK_P2LO;
         end
         SRC_NAND_P2: begin
            modeMask = `SW_MASK_P2ALL;
         end
         SRC_NAND_P3: begin
            modeMask = `SW_MASK_P3HI;
         end
         SRC_NOR_P3: begin
            modeMask = `SW_MASK_P3HI;
            modeNor  = 1'b1;
         end
         SRC_NOR_P3P0: begin
            modeMask = `SW_MASK_P3P0;
            modeNor  = 1'b1;
         end
         SRC_NAND_P3P0: begin
            modeMask = `SW_MASK_P3P0;
         end
         SRC_NAND_P3P2: begin
            modeMask = `SW_MASK_P3P2;
         end
         default: begin
            modeMask = `SW_MASK_NONE;
            modeNor  = 1'b0;
         end
      endcase
   end

   always_comb begin
      inGroup = modeMask & ~pinIgnore;
   end

   // -----------------------------------------------------------
   // gates: raw pins for the stopped-clock path, filtered pins for status
   // -----------------------------------------------------------
   wake_gate #(
      .N       (`SW_NPINS)
   ) rawGateUnit (
      .pins    (pinRaw),
      .inGroup (inGroup),
      .useNor  (modeNor),
      .gateOut (rawGate),
      .active  (rawActive)
   );

   wake_gate #(
      .N       (`SW_NPINS)
   ) syncGateUnit (
      .pins    (pinState),
      .inGroup (inGroup),
      .useNor  (modeNor),
      .gateOut (syncGate),
      .active  (syncActive)
   );

   // -----------------------------------------------------------
   // wake request
   // -----------------------------------------------------------
   // with every chosen pin ignored the gate has no input, so no event
   // is raised rather than a constant one
   always_comb begin
      groupWake     = rawActive && (rawGate == level);
      syncGroupWake = syncActive && (syncGate == level);
      // no clock is needed here, so it still works while stopped
      wakeRequest   = groupWake || perPinWake;
   end

   // -----------------------------------------------------------
   // sticky status, clear on read, interrupt
   // -----------------------------------------------------------
   always_comb begin
      statusSet              = `SW_ST_RST;
      statusSet[`SW_ST_GROUP] = syncGroupWake;
      statusSet[`SW_ST_PIN]   = perPinWake;
      // a set in the cycle of the clearing read wins
      if (rdStatus) begin
         next_status = statusSet;
      end else begin
         next_status = status | statusSet;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status <= `SW_ST_RST;
      end else begin
         status <= next_status;
      end
   end

   // irq follows next_status so it rises with the status bit, not a cycle later
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_status & mask);
      end
   end

   // -----------------------------------------------------------
   // read data, valid only in the cycle after the read strobe
   // -----------------------------------------------------------
   // group and pin-select registers are write-only and read as zero; the mask reads back
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= `SW_RD_ZERO;
      end else if (rdStatus) begin
         regRdata <= {{(8-`SW_ST_W){1'b0}}, status};
      end else if (rdMask) begin
         regRdata <= {{(8-`SW_ST_W){1'b0}}, mask};
      end else begin
         regRdata <= `SW_RD_ZERO;
      end
   end

endmodule // stop_wake_source

// file: test/stop_wake_source_assertions.sv
// port checker of the stop-wake group source
`timescale 1ns/1ns
`include "stop_wake_defs.svh"

module stop_wake_source_assertions (
   // clock and reset
   input wire logic                  mclk,
   input wire logic                  rst_n,
   // register port
   input wire logic [`SW_ADDR_W-1:0] regAddr,
   input wire logic [7:0]            regWdata,
   input wire logic                  regWrite,
   input wire logic                  regRead,
   input wire logic [7:0]            regRdata,
   // pins
   input wire logic [7:0]            port2Pin,
   input wire logic [3:0]            port3Pin,
   input wire logic [7:0]            port2Output,
   input wire logic [3:0]            port3Output,
   input wire logic                  perPinWake,
   // results
   input wire logic                  groupWake,
   input wire logic                  wakeRequest,
   input wire logic [7:0]            port2PinSelect,
   input wire logic [3:0]            port3PinSelect
);
   logic [2:0] src;
   logic       lvl;

   // mirror of the write-only source and level fields
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         src <= 3'h0;
         lvl <= 1'b0;
      end else if (regWrite && regAddr == `SW_GROUP_OFS) begin
         src <= regWdata[`SW_SRC_HI:`SW_SRC_LO];
         lvl <= regWdata[`SW_LEVEL_BIT];
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_wake_merge: assert property (wakeRequest == (groupWake | perPinWake))
      else $error("wake request is not the OR of its sources");
   a_none_quiet: assert property (src == 3'h0 |-> !groupWake)
      else $error("group event with no source selected");
   a_nand_low: assert property (src == 3'h1 && port2Output[3:0] == 4'h0 && port2PinSelect[3:0] == 4'h0
      |-> groupWake == (!(&port2Pin[3:0]) == lvl)) else $error("low port2 nand event wrong");
   a_nand_mixed: assert property (src == 3'h7 && port2Output[2:0] == 3'h0 && port3Output[3:1] == 3'h0
      && port2PinSelect[2:0] == 3'h0 && port3PinSelect[3:1] == 3'h0
      |-> groupWake == (!(&{port3Pin[3:1], port2Pin[2:0]}) == lvl)) else $error("mixed nand event wrong");
   a_nor_port3: assert property (src == 3'h4 && port3Output[3:1] == 3'h0 && port3PinSelect[3:1] == 3'h0
      |-> groupWake == (!(|port3Pin[3:1]) == lvl)) else $error("port3 nor event wrong");
   a_outputs_ignored: assert property (src == 3'h1 && (&port2Output[3:0]) |-> !groupWake)
      else $error("event from output pins");
   a_selects_ignored: assert property (src == 3'h1 && (&port2PinSelect[3:0]) |-> !groupWake)
      else $error("event from per-pin selected pins");
   a_select_load: assert property (regWrite && regAddr == `SW_P2SEL_OFS |=> port2PinSelect == $past(regWdata))
      else $error("port2 select not loaded");
   a_wo_read: assert property (regRead && regAddr == `SW_GROUP_OFS |=> regRdata == 8'h00)
      else $error("group register read back");
endmodule // stop_wake_source_assertions

bind stop_wake_source stop_wake_source_assertions u_chk (.*);

// file: test/pin_partner.sv
// external pin drivers in front of the wake source
`timescale 1ns/1ns

module pin_partner (
   // levels asked for by the bench
   input wire logic [13:0] pinLevels,
   // pins
   output logic     [7:0]  port2Pin,
   output logic     [3:0]  port3Pin,
   output logic            port0Pin0,
   output logic            port0Pin7
);
   // pins are plain levels, they change whenever the outside world does
   assign {port0Pin7, port0Pin0, port3Pin, port2Pin} = pinLevels;
endmodule // pin_partner

// file: test/tb_top.sv
// self-checking bench of the stop-wake group source
`timescale 1ns/1ns
`include "stop_wake_defs.svh"

module tb_top;
   logic        mclk, rst_n, regWrite, regRead, perPinWake, port0Output0, port0Output7;
   logic        port0Pin0, port0Pin7, groupWake, wakeRequest, irq;
   logic [11:0] regAddr;
   logic [7:0]  regWdata, regRdata, port2Pin, port2Output, port2PinSelect, rdv;
   logic [3:0]  port3Pin, port3Output, port3PinSelect;
   logic [13:0] pinLevels;
   int          err_count, n_checks;

   typedef struct packed { logic [7:0] cfg; logic [13:0] pins; logic exp; } row_t;
   // reserved bits written as bit7=0, bit5=1, bits1:0=00
   row_t rows [17] = '{'{8'h20, 14'h3fff, 1'b0}, '{8'h60, 14'h0000, 1'b0}, '{8'h24, 14'h3fff, 1'b1},
      '{8'h24, 14'h3ffe, 1'b0}, '{8'h64, 14'h3ffe, 1'b1}, '{8'h28, 14'h3f7f, 1'b0}, '{8'h68, 14'h3f7f, 1'b1},
      '{8'h2c, 14'h3fff, 1'b1}, '{8'h2c, 14'h3dff, 1'b0}, '{8'h30, 14'h0000, 1'b0}, '{8'h70, 14'h0000, 1'b1},
      '{8'h74, 14'h0000, 1'b1}, '{8'h34, 14'h2000, 1'b1}, '{8'h38, 14'h3e00, 1'b1}, '{8'h38, 14'h1e00, 1'b0},
      '{8'h3c, 14'h0e07, 1'b1}, '{8'h3c, 14'h0e06, 1'b0}};

   stop_wake_source DUT (.*);
   pin_partner u_pins (.*);

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [11:0] a);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 rdv = regRdata;
   endtask

   task automatic pins(input logic [13:0] p);
      @(posedge mclk);
      pinLevels <= p;
      #1;
   endtask

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      {rst_n, regWrite, regRead, perPinWake, port0Output0, port0Output7} = 6'h00;
      {regAddr, regWdata, port2Output, port3Output} = 32'h0;
      pinLevels = 14'h3fff;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      chk({7'h00, groupWake}, 8'h00);
      chk({7'h00, irq}, 8'h00);
      foreach (rows[i]) begin
         wr(`SW_GROUP_OFS, rows[i].cfg);
         pins(rows[i].pins);
         chk({7'h00, groupWake}, {7'h00, rows[i].exp});
         chk({7'h00, wakeRequest}, {7'h00, rows[i].exp});
      end
      // a low pin that is an output or per-pin selected must not block the nand
      wr(`SW_GROUP_OFS, 8'h24);
      pins(14'h3ffe);
      @(posedge mclk) port2Output <= 8'h01;
      #1 chk({7'h00, groupWake}, 8'h01);
      @(posedge mclk) port2Output <= 8'h0f;
      #1 chk({7'h00, groupWake}, 8'h00);
      @(posedge mclk) port2Output <= 8'h00;
      wr(`SW_P2SEL_OFS, 8'h01);
      chk({7'h00, groupWake}, 8'h01);
      wr(`SW_P2SEL_OFS, 8'h0f);
      chk({7'h00, groupWake}, 8'h00);
      chk(port2PinSelect, 8'h0f);
      wr(`SW_P2SEL_OFS, 8'h00);
      // port 3 selects and directions, then port 0 directions, drop pins the same way
      wr(`SW_GROUP_OFS, 8'h2c);
      pins(14'h3dff);
      chk({7'h00, groupWake}, 8'h00);
      wr(`SW_P3SEL_OFS, 8'h02);
      chk({7'h00, groupWake}, 8'h01);
      chk({4'h0, port3PinSelect}, 8'h02);
      wr(`SW_P3SEL_OFS, 8'h00);
      chk({7'h00, groupWake}, 8'h00);
      @(posedge mclk) port3Output <= 4'h2;
      #1 chk({7'h00, groupWake}, 8'h01);
      @(posedge mclk) port3Output <= 4'h0;
      wr(`SW_GROUP_OFS, 8'h38);
      pins(14'h0e00);
      chk({7'h00, groupWake}, 8'h00);
      @(posedge mclk) port0Output0 <= 1'b1;
      #1 chk({7'h00, groupWake}, 8'h00);
      @(posedge mclk) port0Output7 <= 1'b1;
      #1 chk({7'h00, groupWake}, 8'h01);
      @(posedge mclk) {port0Output7, port0Output0} <= 2'b00;
      wr(`SW_GROUP_OFS, 8'h24);
      pins(14'h3ffe);
      @(posedge mclk) perPinWake <= 1'b1;
      #1 chk({7'h00, wakeRequest}, 8'h01);
      @(posedge mclk) perPinWake <= 1'b0;
      // interrupt: mask, raise, clear by status read, then masked event
      wr(`SW_MASK_OFS, 8'h01);
      rd(`SW_MASK_OFS);
      chk(rdv, 8'h01);
      rd(`SW_GROUP_OFS);
      chk(rdv, 8'h00);
      rd(12'h123);
      chk(rdv, 8'h00);
      rd(`SW_STATUS_OFS);
      pins(14'h3fff);
      repeat (8) @(posedge mclk);
      #1 chk({7'h00, irq}, 8'h01);
      chk({7'h00, groupWake}, 8'h01);
      pins(14'h3ffe);
      repeat (8) @(posedge mclk);
      rd(`SW_STATUS_OFS);
      chk(rdv, 8'h01);
      rd(`SW_STATUS_OFS);
      chk(rdv, 8'h00);
      @(posedge mclk);
      #1 chk({7'h00, irq}, 8'h00);
      wr(`SW_MASK_OFS, 8'h00);
      pins(14'h3fff);
      repeat (8) @(posedge mclk);
      #1 chk({7'h00, irq}, 8'h00);
      rd(`SW_STATUS_OFS);
      chk(rdv, 8'h01);
      // only reset clears the group register
      @(posedge mclk) rst_n <= 1'b0;
      #1 chk({7'h00, groupWake}, 8'h00);
      stop_test();
   end

   // the whole run is well under a thousand cycles
   initial begin
      #100000;
      err_count++;
      stop_test();
   end
endmodule // tb_top
